// [logic/udmah_host.sv]
// How it works
// R1: Device pauses data-in only after one word, by withholding strobe edges.
// R2: Host never asserts STOP merely because the device strobe went quiet.
// R3: A fresh device strobe edge resumes a paused data-in burst.
// R4: Host terminates after one word by negating HDMARDY, held until burst end.
// R5: Device stops strobe edges within tRFS of HDMARDY negation.
// R6: Host accepts words arriving after HDMARDY negation, up to two.
// R7: Host asserts STOP no sooner than tRP after HDMARDY negation, held to end.
// R8: Device drops DMARQ within tLI of STOP and keeps it low till done.
// R9: Device lifts a low DSTROBE after STOP; host ignores that edge.
// R10: Device releases the data bus within tAZ of dropping DMARQ.
// R11: Host drives bus no sooner than tZAH after DMARQ drops, with its CRC.
// R12: Host negates DMACK tMLI after end conditions and tDVS after CRC.
// R13: Device latches host CRC when DMACK negates and reports first mismatch.
// R14: Device releases DSTROBE within tIORDYZ of DMACK negation.
// R15: Host holds STOP, HDMARDY negated, strobes and addresses idle for tACK.
// R16: Device asserts DMARQ to start data-out while DMACK stays negated.
// R17: Host sets STOP, HSTROBE high, selects idle, tACK before asserting DMACK.
// R18: Device may drive DDMARDY after DMACK and keeps driving till burst end.
// R19: Host negates STOP soon after DMACK, not reasserting before first HSTROBE fall.
// R20: Device asserts DDMARDY after STOP drops and holds it till first HSTROBE fall.
// R21: Host transfers first word by HSTROBE fall tDVS after data and DDMARDY.
// R22: Host toggles HSTROBE tDVS after data, paced by tCYC, holding data tDVH.
// R23: Burst CRC seeded with 4ABAh before any word of every burst.
// R24: Every timing figure is a clock count rounded to keep its limit.
`timescale 1ns/1ps
module udmah_host (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        burst_en,
    input  wire logic        burst_dir,
    input  wire logic        in_term,
    input  wire logic [15:0] tx_data,
    input  wire logic        tx_valid,
    input  wire logic        tx_last,
    output logic             tx_ready,
    output logic      [15:0] rx_data,
    output logic             rx_valid,
    output logic             burst_done,
    output logic      [15:0] crc_sent,
    output logic             busy,
    input  wire logic        dmarq,
    input  wire logic        iordy_line,
    output logic             dmack_n,
    output logic             stop_line,
    output logic             iord_line,
    output logic             cs0_n,
    output logic             cs1_n,
    output logic      [2:0]  addr,
    input  wire logic [15:0] d_in,
    output logic      [15:0] d_out,
    output logic             d_oe
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [17:0] pins_sync;
    logic        s_dmarq;
    logic        s_iordy;
    logic [15:0] s_d;

    udmah_sync #(
        .W (18)
    ) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .d       ({dmarq, iordy_line, d_in}),
        .q       (pins_sync)
    );

    assign s_dmarq = pins_sync[17];
    assign s_iordy = pins_sync[16];
    assign s_d     = pins_sync[15:0];

    // The register-file selects stay idle: this block only runs bursts.
    assign cs0_n = 1'b1;
    assign cs1_n = 1'b1;
    assign addr  = 3'h0;

    // ----------------------------------------------------------------
    // Burst check function
    // ----------------------------------------------------------------
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] w);
        logic [15:0] r;
        logic        fb;
        r = c;
        for (int i = 0; i < 16; i++) begin
            fb = r[15] ^ w[i];
            r  = {r[14:0], 1'b0} ^ (fb ? udmah_pkg::CRC_POLY : 16'h0000);
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    udmah_pkg::udmah_state_t state;
    udmah_pkg::udmah_state_t next_state;
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic        iordy_q;
    logic        next_iordy_q;
    logic        dir_q;
    logic        next_dir_q;
    logic        moved;
    logic        next_moved;
    logic        phase;
    logic        next_phase;
    logic        last_q;
    logic        next_last_q;
    logic [15:0] crc;
    logic [15:0] next_crc;
    logic        next_dmack_n;
    logic        next_stop_line;
    logic        next_iord_line;
    logic [15:0] next_d_out;
    logic        next_d_oe;
    logic [15:0] next_rx_data;
    logic        next_rx_valid;
    logic        next_burst_done;
    logic [15:0] next_crc_sent;
    logic        strobe_edge;
    logic        out_take;

    assign strobe_edge = s_iordy ^ iordy_q;
    // The device asserts DDMARDY by pulling the line low.
    assign out_take    = (state == udmah_pkg::UDMAH_OUT_RUN) && !phase && (cnt == 16'h0000)
                         && !s_iordy && s_dmarq;
    assign tx_ready    = out_take;
    assign busy        = (state != udmah_pkg::UDMAH_IDLE);

    always_comb begin
        next_state      = state;
        next_cnt        = cnt;
        next_iordy_q    = s_iordy;
        next_dir_q      = dir_q;
        next_moved      = moved;
        next_phase      = phase;
        next_last_q     = last_q;
        next_crc        = crc;
        next_dmack_n    = dmack_n;
        next_stop_line  = stop_line;
        next_iord_line  = iord_line;
        next_d_out      = d_out;
        next_d_oe       = d_oe;
        next_rx_data    = rx_data;
        next_rx_valid   = 1'b0;
        next_burst_done = 1'b0;
        next_crc_sent   = crc_sent;
        case (state)
            udmah_pkg::UDMAH_IDLE: begin
                // R16: start only on a device request while DMACK is negated.
                if (burst_en && s_dmarq) begin
                    next_dir_q     = burst_dir;
                    // R17: STOP and HSTROBE (or HDMARDY negated) set before DMACK.
                    next_stop_line = 1'b1;
                    next_iord_line = 1'b1;
                    next_d_oe      = 1'b0;
                    // R23: seed burst CRC.
                    next_crc       = udmah_pkg::CRC_SEED;
                    next_moved     = 1'b0;
                    next_phase     = 1'b0;
                    next_last_q    = 1'b0;
                    // R24: setup time as whole cycles.
                    next_cnt       = udmah_pkg::C_ACK;
                    next_state     = udmah_pkg::UDMAH_ACK;
                end
            end
            udmah_pkg::UDMAH_ACK: begin
                // R17: tACK of setup before DMACK asserts.
                if (cnt > 16'h0001) begin
                    next_cnt = cnt - 16'h0001;
                end else begin
                    next_dmack_n = 1'b0;
                    next_state   = udmah_pkg::UDMAH_ENV;
                end
            end
            udmah_pkg::UDMAH_ENV: begin
                // R19: STOP drops one cycle after DMACK, inside tENV.
                next_stop_line = 1'b0;
                next_cnt       = 16'h0000;
                if (!dir_q) begin
                    next_iord_line = 1'b0;
                    next_state     = udmah_pkg::UDMAH_IN_RUN;
                end else begin
                    next_state = udmah_pkg::UDMAH_OUT_RUN;
                end
            end
            udmah_pkg::UDMAH_IN_RUN: begin
                // R1: strobe edges carry words; R3: a new edge after a pause resumes.
                if (strobe_edge) begin
                    next_rx_data  = s_d;
                    next_rx_valid = 1'b1;
                    next_crc      = crc_step(crc, s_d);
                    next_moved    = 1'b1;
                end
                // R2: a quiet strobe alone never leads to STOP.
                if (!s_dmarq) begin
                    next_iord_line = 1'b1;
                    next_stop_line = 1'b1;
                    next_state     = udmah_pkg::UDMAH_IN_STOP;
                end else if (in_term && (moved || strobe_edge)) begin
                    // R4: negate HDMARDY to end, only after a word has moved.
                    next_iord_line = 1'b1;
                    next_cnt       = udmah_pkg::C_RP;
                    next_state     = udmah_pkg::UDMAH_IN_HALT;
                end
            end
            udmah_pkg::UDMAH_IN_HALT: begin
                // R6: words still arriving after HDMARDY negation are kept.
                if (strobe_edge) begin
                    next_rx_data  = s_d;
                    next_rx_valid = 1'b1;
                    next_crc      = crc_step(crc, s_d);
                end
                // R7: STOP no sooner than tRP after HDMARDY negation.
                if (cnt > 16'h0001) begin
                    next_cnt = cnt - 16'h0001;
                end else begin
                    next_stop_line = 1'b1;
                    next_state     = udmah_pkg::UDMAH_IN_STOP;
                end
            end
            udmah_pkg::UDMAH_IN_STOP: begin
                // R9: strobe edges after STOP carry no data and are ignored.
                // R8: wait for the device to drop its request.
                if (!s_dmarq) begin
                    next_cnt   = udmah_pkg::C_ZAH;
                    next_state = udmah_pkg::UDMAH_IN_ZAH;
                end
            end
            udmah_pkg::UDMAH_IN_ZAH: begin
                // R10: the device has released the bus by the time this ends.
                if (cnt > 16'h0001) begin
                    next_cnt = cnt - 16'h0001;
                end else begin
                    // R11: first value driven is the burst CRC.
                    next_d_out = crc;
                    next_d_oe  = 1'b1;
                    next_cnt   = udmah_pkg::C_CRC;
                    next_state = udmah_pkg::UDMAH_CRC_HOLD;
                end
            end
            udmah_pkg::UDMAH_OUT_RUN: begin
                if (phase) begin
                    // R21: strobe edge no sooner than tDVS after data and DDMARDY.
                    if (cnt > 16'h0001) begin
                        next_cnt = cnt - 16'h0001;
                    end else begin
                        next_iord_line = ~iord_line;
                        next_moved     = 1'b1;
                        next_phase     = 1'b0;
                        // R22: pace by tCYC and hold data tDVH before the next word.
                        next_cnt       = udmah_pkg::C_HOLD;
                        if (last_q) begin
                            next_cnt   = udmah_pkg::C_SS;
                            next_state = udmah_pkg::UDMAH_OUT_SS;
                        end
                    end
                end else if (!s_dmarq && moved) begin
                    next_stop_line = 1'b1;
                    next_state     = udmah_pkg::UDMAH_OUT_END;
                end else if (cnt != 16'h0000) begin
                    next_cnt = cnt - 16'h0001;
                end else if (out_take && tx_valid) begin
                    // R22: drive the word, then wait tDVS before the edge.
                    next_d_out  = tx_data;
                    next_d_oe   = 1'b1;
                    next_crc    = crc_step(crc, tx_data);
                    next_last_q = tx_last;
                    next_cnt    = udmah_pkg::C_DVS;
                    next_phase  = 1'b1;
                end
            end
            udmah_pkg::UDMAH_OUT_SS: begin
                // R19: STOP only after the first HSTROBE fall, tSS after last edge.
                if (cnt > 16'h0001) begin
                    next_cnt = cnt - 16'h0001;
                end else begin
                    next_stop_line = 1'b1;
                    next_state     = udmah_pkg::UDMAH_OUT_END;
                end
            end
            udmah_pkg::UDMAH_OUT_END: begin
                if (!s_dmarq) begin
                    // HSTROBE returns high without a word, and the CRC is shown in the same cycle.
                    next_iord_line = 1'b1;
                    next_d_out     = crc;
                    next_d_oe      = 1'b1;
                    next_cnt       = udmah_pkg::C_CRC;
                    next_state     = udmah_pkg::UDMAH_CRC_HOLD;
                end
            end
            udmah_pkg::UDMAH_CRC_HOLD: begin
                // R12: device line must read high before tMLI and tDVS count.
                if (!s_iordy) begin
                    next_cnt = udmah_pkg::C_CRC;
                end else if (cnt > 16'h0001) begin
                    next_cnt = cnt - 16'h0001;
                end else begin
                    // R13: DMACK negation is the moment the device latches the CRC.
                    next_dmack_n  = 1'b1;
                    next_crc_sent = d_out;
                    next_cnt      = udmah_pkg::C_ACK;
                    next_state    = udmah_pkg::UDMAH_REL;
                end
            end
            udmah_pkg::UDMAH_REL: begin
                // R15: STOP and strobe lines held tACK after DMACK negation.
                if (cnt > 16'h0001) begin
                    next_cnt = cnt - 16'h0001;
                end else begin
                    next_stop_line  = 1'b0;
                    next_iord_line  = 1'b1;
                    next_d_oe       = 1'b0;
                    next_burst_done = 1'b1;
                    next_state      = udmah_pkg::UDMAH_IDLE;
                end
            end
            default: begin
                next_state = udmah_pkg::UDMAH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state      <= udmah_pkg::UDMAH_IDLE;
            cnt        <= 16'h0000;
            iordy_q    <= 1'b0;
            dir_q      <= 1'b0;
            moved      <= 1'b0;
            phase      <= 1'b0;
            last_q     <= 1'b0;
            crc        <= udmah_pkg::CRC_SEED;
            dmack_n    <= 1'b1;
            stop_line  <= 1'b0;
            iord_line  <= 1'b1;
            d_out      <= 16'h0000;
            d_oe       <= 1'b0;
            rx_data    <= 16'h0000;
            rx_valid   <= 1'b0;
            burst_done <= 1'b0;
            crc_sent   <= 16'h0000;
        end else begin
            state      <= next_state;
            cnt        <= next_cnt;
            iordy_q    <= next_iordy_q;
            dir_q      <= next_dir_q;
            moved      <= next_moved;
            phase      <= next_phase;
            last_q     <= next_last_q;
            crc        <= next_crc;
            dmack_n    <= next_dmack_n;
            stop_line  <= next_stop_line;
            iord_line  <= next_iord_line;
            d_out      <= next_d_out;
            d_oe       <= next_d_oe;
            rx_data    <= next_rx_data;
            rx_valid   <= next_rx_valid;
            burst_done <= next_burst_done;
            crc_sent   <= next_crc_sent;
        end
    end

endmodule

// [logic/udmah_pkg.sv]
package udmah_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;

    // Least times, in ns, for the active transfer mode.
    localparam int T_ACK_NS = 20;
    localparam int T_RP_NS  = 160;
    localparam int T_MLI_NS = 20;
    localparam int T_DVS_NS = 70;
    localparam int T_DVH_NS = 10;
    localparam int T_CYC_NS = 115;
    localparam int T_ZAH_NS = 20;
    localparam int T_SS_NS  = 50;

    // Converts a least time to whole clock cycles, rounding up, never below one.
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int imax(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    localparam logic [15:0] C_ACK  = 16'(cyc_min(T_ACK_NS));
    localparam logic [15:0] C_RP   = 16'(cyc_min(T_RP_NS));
    localparam logic [15:0] C_DVS  = 16'(cyc_min(T_DVS_NS));
    localparam logic [15:0] C_ZAH  = 16'(cyc_min(T_ZAH_NS));
    localparam logic [15:0] C_SS   = 16'(cyc_min(T_SS_NS));
    localparam logic [15:0] C_CRC  = 16'(imax(cyc_min(T_MLI_NS), cyc_min(T_DVS_NS)));
    localparam logic [15:0] C_HOLD = 16'(imax(cyc_min(T_DVH_NS), cyc_min(T_CYC_NS - T_DVS_NS)));

    // ----------------------------------------------------------------
    // Burst check value
    // ----------------------------------------------------------------
    localparam logic [15:0] CRC_SEED = 16'h4aba;
    localparam logic [15:0] CRC_POLY = 16'h1021;

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        UDMAH_IDLE,
        UDMAH_ACK,
        UDMAH_ENV,
        UDMAH_IN_RUN,
        UDMAH_IN_HALT,
        UDMAH_IN_STOP,
        UDMAH_IN_ZAH,
        UDMAH_OUT_RUN,
        UDMAH_OUT_SS,
        UDMAH_OUT_END,
        UDMAH_CRC_HOLD,
        UDMAH_REL
    } udmah_state_t;

endpackage

// [logic/udmah_sync.sv]
`timescale 1ns/1ps
module udmah_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = sys_rst ? '0 : d;
        next_q    = sys_rst ? '0 : meta;
    end

    always_ff @(posedge clk) begin
        meta <= next_meta;
        q    <= next_q;
    end

endmodule

// [test/udmah_host_properties.sv]
`timescale 1ns/1ps
module udmah_host_properties (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        burst_dir,
    input wire logic        rx_valid,
    input wire logic        dmarq,
    input wire logic        dmack_n,
    input wire logic        stop_line,
    input wire logic        iord_line,
    input wire logic        cs0_n,
    input wire logic        cs1_n,
    input wire logic [2:0]  addr,
    input wire logic [15:0] d_out,
    input wire logic        d_oe
);
    localparam int ACK = udmah_pkg::C_ACK;
    localparam int DVS = udmah_pkg::C_DVS;
    localparam int CYC = udmah_pkg::cyc_min(udmah_pkg::T_CYC_NS);
    logic [7:0] hi_cnt, lo_cnt, t_age, next_hi_cnt, next_lo_cnt, next_t_age;
    logic       got, iord_prev, next_got;

    // ------------------------------------------------------------
    // Cycles since pin events
    // ------------------------------------------------------------
    always_comb begin
        next_hi_cnt = (dmack_n || !iord_line) ? 8'h00 : hi_cnt + 8'(hi_cnt != 8'hff);
        next_lo_cnt = dmarq ? 8'h00 : lo_cnt + 8'(lo_cnt != 8'hff);
        next_t_age  = dmack_n ? 8'hff : (iord_line != iord_prev) ? 8'h00 : t_age + 8'(t_age != 8'hff);
        next_got    = !dmack_n && (got || rx_valid);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hi_cnt    <= 8'h00;
            lo_cnt    <= 8'h00;
            t_age     <= 8'hff;
            got       <= 1'b0;
            iord_prev <= 1'b1;
        end else begin
            hi_cnt    <= next_hi_cnt;
            lo_cnt    <= next_lo_cnt;
            t_age     <= next_t_age;
            got       <= next_got;
            iord_prev <= iord_line;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_ack_setup: assert property ($fell(dmack_n) |-> $past(stop_line, ACK) && $past(iord_line, ACK)
        && cs0_n && cs1_n && addr == 3'h0) else $error("acknowledge before setup");
    a_stop_release: assert property ($fell(dmack_n) |=> !stop_line) else $error("stop kept");
    a_no_stop_pause: assert property (!burst_dir && !dmack_n && !iord_line |-> !stop_line)
        else $error("stop while host ready");
    a_no_early_term: assert property (!burst_dir && !dmack_n && !stop_line && $rose(iord_line) |-> got)
        else $error("halt before first word");
    a_stop_after_rp: assert property (!burst_dir && !dmack_n && $rose(stop_line) |-> hi_cnt >= udmah_pkg::C_RP)
        else $error("stop too soon after halt");
    a_zah_drive: assert property (!burst_dir && $rose(d_oe) |-> lo_cnt >= udmah_pkg::C_ZAH)
        else $error("bus driven too soon");
    a_crc_setup: assert property ($rose(dmack_n) |-> d_oe && $past(d_oe, DVS) && d_out == $past(d_out, DVS))
        else $error("check value not settled");
    a_hold_tack: assert property ($rose(dmack_n) |-> (stop_line && iord_line && cs0_n && cs1_n)[*4])
        else $error("pins moved in release hold");
    a_dvs_strobe: assert property (burst_dir && !dmack_n && !stop_line && iord_line != $past(iord_line)
        |-> d_out == $past(d_out, DVS)) else $error("strobe before data settled");
    a_cyc_space: assert property (burst_dir && !dmack_n && !stop_line && iord_line != iord_prev
        |-> t_age >= CYC - 1) else $error("strobe edges too close");
endmodule

// [test/udmah_dev_model.sv]
`timescale 1ns/1ps
module udmah_dev_model (
    input  wire logic        go,
    input  wire logic        dir,
    input  wire logic [7:0]  nw,
    input  wire logic [15:0] base,
    input  wire logic        dmack_n,
    input  wire logic        stop_line,
    input  wire logic        iord_line,
    input  wire logic [15:0] d_bus,
    output logic             dmarq = 1'b0,
    output logic             iordy_line = 1'b1,
    output logic      [15:0] d_dev = 16'h0000,
    output logic             d_dev_oe = 1'b0,
    output logic             got = 1'b0,
    output logic      [15:0] word = 16'h0000,
    output logic      [15:0] crc = 16'h0000,
    output logic             crc_err = 1'b0,
    output int               sent = 0
);
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] w);
        for (int b = 0; b < 16; b++) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ w[b]) ? 16'h1021 : 16'h0000);
        end
        return c;
    endfunction

    // ------------------------------------------------------------
    // One burst per rising go; data-in strobe edges 120 ns apart, 520 ns after the second.
    // ------------------------------------------------------------
    always @(posedge go) begin
        crc = udmah_pkg::CRC_SEED;
        sent = 0;
        dmarq = 1'b1;
        wait (!dmack_n);
        if (!dir) begin
            wait (!stop_line && !iord_line);
            while (sent < nw) begin
                d_dev_oe = 1'b1;
                d_dev = base + 16'(sent);
                #70;
                if (iord_line) break;
                crc = crc_step(crc, d_dev);
                iordy_line = ~iordy_line;
                sent++;
                #50;
                if (sent == 2) #400;
            end
            wait (stop_line);
            #10;
            dmarq = 1'b0;
            iordy_line = 1'b1;
            #10;
            d_dev_oe = 1'b0;
        end else begin
            wait (!stop_line);
            #10;
            iordy_line = 1'b0;
            while (!stop_line) begin
                @(iord_line or stop_line);
                if (!stop_line) begin
                    word = d_bus;
                    crc = crc_step(crc, word);
                    sent++;
                    got = 1'b1;
                    #1;
                    got = 1'b0;
                    // The stall runs aside so strobe edges are still caught.
                    if (sent == 2) fork
                        begin
                            iordy_line = 1'b1;
                            #300;
                            iordy_line = 1'b0;
                        end
                    join_none
                end
            end
            #10;
            dmarq = 1'b0;
            iordy_line = 1'b1;
        end
        // latch host value, strobe stays released.
        @(posedge dmack_n);
        crc_err = (d_bus !== crc);
    end
endmodule

// [test/test_udmah_host.sv]
`timescale 1ns/1ps
module test_udmah_host;
    logic        clk = 1'b0, sys_rst = 1'b1, burst_en = 1'b0, burst_dir = 1'b0, in_term = 1'b0, go = 1'b0;
    logic        tx_valid = 1'b0, tx_last = 1'b0;
    logic [15:0] tx_data = 16'h0000, base = 16'h0000;
    logic [7:0]  nw = 8'h06;
    logic        tx_ready, rx_valid, burst_done, busy, dmarq, iordy_line, dmack_n, stop_line;
    logic        iord_line, cs0_n, cs1_n, d_oe, d_dev_oe, got, crc_err;
    logic [2:0]  addr;
    logic [15:0] rx_data, crc_sent, d_out, d_in, d_dev, word, crc, e_in, e_out;
    logic [15:0] q[$];
    int          error_cnt = 0, n_checks = 0, seed = 80, sent, nrx = 0;

`define CHK(nm, ex, sn) begin n_checks++; if ((sn) !== (ex)) begin error_cnt++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, sn); end end

    always #2.5 clk = ~clk;
    // A bus that neither side drives shows the inverse of the device's last value.
    assign d_in = d_oe ? d_out : (d_dev_oe ? d_dev : ~d_dev);

    udmah_host u_udmah_host (
        .clk, .sys_rst, .burst_en, .burst_dir, .in_term, .tx_data, .tx_valid, .tx_last, .tx_ready, .rx_data,
        .rx_valid, .burst_done, .crc_sent, .busy, .dmarq, .iordy_line, .dmack_n, .stop_line, .iord_line,
        .cs0_n, .cs1_n, .addr, .d_in, .d_out, .d_oe
    );
    udmah_dev_model u_udmah_dev_model (
        .go, .dir(burst_dir), .nw, .base, .dmack_n, .stop_line, .iord_line, .d_bus(d_in), .dmarq,
        .iordy_line, .d_dev, .d_dev_oe, .got, .word, .crc, .crc_err, .sent
    );

    // ------------------------------------------------------------
    // Result monitors
    // ------------------------------------------------------------
    always @(posedge clk) if (rx_valid === 1'b1) begin
        e_in = q.pop_front();
        nrx++;
        `CHK("rx_data", e_in, rx_data)
    end
    always @(posedge got) begin
        e_out = q.pop_front();
        `CHK("dev_word", e_out, word)
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic wait_done();
        for (int i = 0; i < 4000 && burst_done !== 1'b1; i++) @(negedge clk);
        `CHK("burst_done", 1'b1, burst_done)
        @(posedge clk);
    endtask

    task automatic run_in(input int k);
        q.delete();
        nrx = 0;
        base <= 16'($random(seed));
        burst_dir <= 1'b0;
        burst_en <= 1'b1;
        go <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 6; i++) q.push_back(base + 16'(i));
        while (nrx < k) @(posedge clk);
        in_term <= 1'b1;
        go <= 1'b0;
        wait_done();
        in_term <= 1'b0;
        `CHK("word_count", sent, nrx)
        `CHK("crc_sent", crc, crc_sent)
        `CHK("crc_err", 1'b0, crc_err)
        $display("data-in test of %0d words done", k);
    endtask

    task automatic run_out(input int n);
        q.delete();
        burst_dir <= 1'b1;
        go <= 1'b1;
        for (int i = 0; i < n; i++) begin
            tx_data <= 16'($random(seed));
            tx_last <= 1'(i == n - 1);
            tx_valid <= 1'b1;
            do @(negedge clk); while (tx_ready !== 1'b1);
            @(posedge clk);
            q.push_back(tx_data);
        end
        tx_valid <= 1'b0;
        tx_last <= 1'b0;
        go <= 1'b0;
        wait_done();
        `CHK("out_words", n, sent)
        `CHK("crc_sent", crc, crc_sent)
        `CHK("crc_err", 1'b0, crc_err)
        $display("data-out test of %0d words done", n);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(negedge clk);
        `CHK("idle_pins", 5'h14, {dmack_n, stop_line, iord_line, d_oe, busy})
        `CHK("bus_idle", 5'h18, {cs0_n, cs1_n, addr})
        $display("reset test done");
        @(posedge clk);
        run_in(1);
        run_in(4);
        run_out(4);
        run_out(1);
        final_report();
    end

    initial begin
        #100000;
        error_cnt++;
        $display("[FAIL] watchdog expected finish seen hang");
        final_report();
    end
endmodule

bind udmah_host udmah_host_properties u_udmah_host_properties (
    .clk, .sys_rst, .burst_dir, .rx_valid, .dmarq, .dmack_n, .stop_line, .iord_line, .cs0_n, .cs1_n, .addr,
    .d_out, .d_oe
);
